// [shared/lab_pkg.sv]
package lab_pkg;
  localparam int          DW         = 16;
  localparam int          SITE_W     = 8;
  localparam logic [7:0]  OFF_FUNC   = 8'h00;
  localparam logic [7:0]  OFF_RX_ST  = 8'h04;
  localparam logic [7:0]  OFF_TX_ST  = 8'h08;
  localparam logic [7:0]  OFF_IRQ_ST = 8'h0c;
  localparam logic [7:0]  OFF_RX_FWA = 8'h10;
  localparam logic [7:0]  OFF_RX_LWA = 8'h14;
  localparam logic [7:0]  OFF_TX_FWA = 8'h18;
  localparam logic [7:0]  OFF_TX_LWA = 8'h1c;
  localparam logic [7:0]  OFF_RX_CUR = 8'h20;
  localparam logic [7:0]  OFF_TX_CUR = 8'h24;
  localparam int          F_RX_CLR   = 0;
  localparam int          F_TX_CLR   = 1;
  localparam int          F_RX_GO    = 2;
  localparam int          F_TX_GO    = 3;
  localparam int          F_EOP_EN   = 4;
  localparam int          F_LOOP     = 5;
  localparam int          F_IRQ_CLR  = 6;
  localparam int          IRQ_RX     = 0;
  localparam int          IRQ_TX     = 1;
  localparam logic [15:0] ST_IDLE    = 16'h0001;
  localparam logic [15:0] ST_RUN     = 16'h0003;
  localparam logic [15:0] ST_OVF     = 16'h0401;
  localparam logic [15:0] ST_PROT    = 16'h1001;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;
  localparam logic [1:0]  RESP_DEC   = 2'h3;
  typedef enum logic [1:0] {
    MS_IDLE,
    MS_TX_RD,
    MS_RX_CHK,
    MS_RX_WR
  } lab_mem_st_t;
endpackage : lab_pkg

// [design/lab_top.sv]
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
// Operation
// [RULE1] interrupt status bit 0 is rx end of operation, bit 1 tx.
// [RULE2] after receiver and transmitter clear both status words read 0001.
// [RULE3] a started receiver reads 0003 while an idle transmitter reads 0001.
// [RULE4] done: tx 0001; rx 0001, 0401 on overflow, 1001 on protect fail.
// [RULE5] host sets both word addresses before a start; writes get a reply.
// [RULE6] both end of operation interrupts may be on; each fires at its end.
// [RULE7] in loopback received words equal transmitted words in order.
// [RULE8] a buffer's first word carries the site switches in its top byte.
// [RULE9] the interrupt line is high only while some status bit is set.
// [RULE10] a clear-interrupts function leaves interrupt status at 0000; a completion in the clearing cycle still sets its bit.
// [RULE11] every access replies normally unless it cannot be taken.
// [RULE12] a longer receiver stops at the sender's end with normal status.
// [RULE13] a protected rx word is not written; protect failure is reported.
// [RULE14] loopback, set by function, feeds tx output to rx input.
// [RULE15] each channel steps first to last address, one word per transfer.
// [RULE16] status reads never disturb a running transfer.
module lab_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wp_r;
  logic [AW:0]  rp_r;
  logic         push;
  logic         pop;
  assign o_in_ready  = (wp_r - rp_r) != (AW+1)'(D);
  assign o_out_valid = wp_r != rp_r;
  assign o_out_data  = mem[rp_r[AW-1:0]];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      wp_r <= wp_r + (AW+1)'(push);
      rp_r <= rp_r + (AW+1)'(pop);
    end
  end
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wp_r[AW-1:0]] <= i_in_data;
  end
endmodule : lab_fifo

module lab_top #(
  parameter int AW    = 16,
  parameter int DEPTH = 16
) (
  input  wire logic                 I_CLK,
  input  wire logic                 I_RST,
  input  wire logic [7:0]           I_AWADDR,
  input  wire logic                 I_AWVALID,
  output logic                      O_AWREADY,
  input  wire logic [31:0]          I_WDATA,
  input  wire logic [3:0]           I_WSTRB,
  input  wire logic                 I_WVALID,
  output logic                      O_WREADY,
  output logic [1:0]                O_BRESP,
  output logic                      O_BVALID,
  input  wire logic                 I_BREADY,
  input  wire logic [7:0]           I_ARADDR,
  input  wire logic                 I_ARVALID,
  output logic                      O_ARREADY,
  output logic [31:0]               O_RDATA,
  output logic [1:0]                O_RRESP,
  output logic                      O_RVALID,
  input  wire logic                 I_RREADY,
  output logic                      O_MEM_REQ,
  output logic                      O_MEM_WE,
  output logic [AW-1:0]             O_MEM_ADDR,
  output logic [lab_pkg::DW-1:0]    O_MEM_WDATA,
  input  wire logic                 I_MEM_ACK,
  input  wire logic [lab_pkg::DW-1:0] I_MEM_RDATA,
  input  wire logic                 I_MEM_PROT,
  input  wire logic [7:0]           I_SITE_ADDR,
  output logic [lab_pkg::DW-1:0]    O_LINK_DATA,
  output logic                      O_LINK_STB,
  output logic                      O_IRQ
);
  localparam int DW = lab_pkg::DW;
  // byte-lane merge for the address registers
  function automatic logic [AW-1:0] merge(input logic [AW-1:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] st);
    logic [AW-1:0] r;
    r = old;
    for (int b = 0; b < AW/8; b++)
      if (st[b])
        r[b*8 +: 8] = wd[b*8 +: 8];
    return r;
  endfunction : merge

  logic [7:0]        site_m_r;
  logic [7:0]        site_r;
  logic              aw_ready_r;
  logic              w_ready_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              ar_ready_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;
  logic [15:0]       rx_st_r;
  logic [15:0]       tx_st_r;
  logic [1:0]        irq_st_r;
  logic              irq_r;
  logic              rx_busy_r;
  logic              tx_busy_r;
  logic              tx_ran_r;
  logic              loop_r;
  logic              rx_eop_en_r;
  logic              tx_eop_en_r;
  logic [AW-1:0]     rx_fwa_r;
  logic [AW-1:0]     rx_lwa_r;
  logic [AW-1:0]     tx_fwa_r;
  logic [AW-1:0]     tx_lwa_r;
  logic [AW-1:0]     rx_cur_r;
  logic [AW-1:0]     tx_cur_r;
  logic [DW-1:0]     rx_word_r;
  logic              mem_req_r;
  logic              mem_we_r;
  logic [AW-1:0]     mem_addr_r;
  logic [DW-1:0]     mem_wdata_r;
  logic [DW-1:0]     link_data_r;
  logic              link_stb_r;
  lab_pkg::lab_mem_st_t ms_r;

  // the write address and write data channels are taken together so the reply follows both
  logic wr_go;
  logic rd_go;
  logic [7:0] wa;
  logic [7:0] ra;
  logic is_func;
  logic fn_ok;
  logic [6:0] fn;
  assign wr_go = aw_ready_r && I_AWVALID && I_WVALID;
  assign rd_go = ar_ready_r && I_ARVALID;
  assign wa    = I_AWADDR;
  assign ra    = I_ARADDR;
  assign is_func = wa == lab_pkg::OFF_FUNC;
  assign fn_ok   = wr_go && is_func && I_WSTRB[0];
  assign fn      = fn_ok ? I_WDATA[6:0] : '0;

  logic rx_clr;
  logic tx_clr;
  logic rx_go;
  logic tx_go;
  logic irq_clr;
  logic fn_rej;
  assign rx_clr  = fn[lab_pkg::F_RX_CLR];
  assign tx_clr  = fn[lab_pkg::F_TX_CLR];
  assign rx_go   = fn[lab_pkg::F_RX_GO] && (!rx_busy_r || rx_clr);
  assign tx_go   = fn[lab_pkg::F_TX_GO] && (!tx_busy_r || tx_clr);
  assign irq_clr = fn[lab_pkg::F_IRQ_CLR];
  // a start on a running channel cannot be taken unless the same write clears it
  assign fn_rej  = (fn[lab_pkg::F_RX_GO] && !rx_go) ||
                   (fn[lab_pkg::F_TX_GO] && !tx_go); // RULE11

  logic wr_rx_fwa;
  logic wr_rx_lwa;
  logic wr_tx_fwa;
  logic wr_tx_lwa;
  logic wr_map;
  logic wr_rej;
  assign wr_rx_fwa = wr_go && wa == lab_pkg::OFF_RX_FWA && !rx_busy_r;
  assign wr_rx_lwa = wr_go && wa == lab_pkg::OFF_RX_LWA && !rx_busy_r;
  assign wr_tx_fwa = wr_go && wa == lab_pkg::OFF_TX_FWA && !tx_busy_r;
  assign wr_tx_lwa = wr_go && wa == lab_pkg::OFF_TX_LWA && !tx_busy_r;
  assign wr_map = is_func || wa == lab_pkg::OFF_RX_FWA ||
                  wa == lab_pkg::OFF_RX_LWA || wa == lab_pkg::OFF_TX_FWA ||
                  wa == lab_pkg::OFF_TX_LWA;
  // address registers of a busy channel refuse writes
  assign wr_rej = fn_rej ||
    (rx_busy_r && (wa == lab_pkg::OFF_RX_FWA || wa == lab_pkg::OFF_RX_LWA)) ||
    (tx_busy_r && (wa == lab_pkg::OFF_TX_FWA || wa == lab_pkg::OFF_TX_LWA));

  logic [1:0] bresp_nxt;
  always_comb
  begin
    if (!wr_map)
      bresp_nxt = lab_pkg::RESP_DEC;
    else if (wr_rej)
      bresp_nxt = lab_pkg::RESP_SLV;
    else
      bresp_nxt = lab_pkg::RESP_OKAY; // RULE5 RULE11
  end

  // reads are side-effect free so status may be polled mid-transfer
  logic [31:0] rd_data;
  logic [1:0]  rd_resp;
  always_comb
  begin
    rd_resp = lab_pkg::RESP_OKAY;
    rd_data = '0;
    if (ra == lab_pkg::OFF_RX_ST)
      rd_data = 32'(rx_st_r); // RULE16
    else if (ra == lab_pkg::OFF_TX_ST)
      rd_data = 32'(tx_st_r); // RULE16
    else if (ra == lab_pkg::OFF_IRQ_ST)
      rd_data = 32'(irq_st_r); // RULE1
    else if (ra == lab_pkg::OFF_RX_FWA)
      rd_data = 32'(rx_fwa_r);
    else if (ra == lab_pkg::OFF_RX_LWA)
      rd_data = 32'(rx_lwa_r);
    else if (ra == lab_pkg::OFF_TX_FWA)
      rd_data = 32'(tx_fwa_r);
    else if (ra == lab_pkg::OFF_TX_LWA)
      rd_data = 32'(tx_lwa_r);
    else if (ra == lab_pkg::OFF_RX_CUR)
      rd_data = 32'(rx_cur_r);
    else if (ra == lab_pkg::OFF_TX_CUR)
      rd_data = 32'(tx_cur_r);
    else if (ra != lab_pkg::OFF_FUNC)
      rd_resp = lab_pkg::RESP_DEC;
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      aw_ready_r <= 1'b0;
      w_ready_r  <= 1'b0;
      bvalid_r   <= 1'b0;
      bresp_r    <= lab_pkg::RESP_OKAY;
      ar_ready_r <= 1'b0;
      rvalid_r   <= 1'b0;
      rdata_r    <= '0;
      rresp_r    <= lab_pkg::RESP_OKAY;
    end
    else
    begin
      aw_ready_r <= !aw_ready_r && !bvalid_r && I_AWVALID && I_WVALID;
      w_ready_r  <= !aw_ready_r && !bvalid_r && I_AWVALID && I_WVALID;
      if (wr_go)
      begin
        bvalid_r <= 1'b1;
        bresp_r  <= bresp_nxt;
      end
      else if (I_BREADY)
        bvalid_r <= 1'b0;
      ar_ready_r <= !ar_ready_r && !rvalid_r && I_ARVALID;
      if (rd_go)
      begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_data;
        rresp_r  <= rd_resp;
      end
      else if (I_RREADY)
        rvalid_r <= 1'b0;
    end
  end

  // site switches are asynchronous levels
  always_ff @(posedge I_CLK)
  begin
    site_m_r <= I_SITE_ADDR;
    site_r   <= site_m_r;
  end

  // transfer engine: one memory access in flight, receiver first
  logic          ack;
  logic          f_in_rdy;
  logic          f_out_vld;
  logic [DW-1:0] f_out_data;
  logic          rx_take;
  logic          tx_take;
  logic          rx_short;
  logic          push;
  logic          pop;
  logic [DW-1:0] push_data;
  logic          prot_fail;
  logic          wr_ok;
  logic          rx_done;
  logic          tx_done;
  logic [15:0]   rx_end_st;
  assign ack      = I_MEM_ACK && mem_req_r;
  assign rx_take  = ms_r == lab_pkg::MS_IDLE && rx_busy_r && loop_r &&
                    f_out_vld; // RULE14
  assign tx_take  = ms_r == lab_pkg::MS_IDLE && !rx_take && tx_busy_r &&
                    f_in_rdy;
  assign rx_short = ms_r == lab_pkg::MS_IDLE && rx_busy_r && loop_r &&
                    tx_ran_r && !tx_busy_r && !f_out_vld; // RULE12
  assign push     = ms_r == lab_pkg::MS_TX_RD && ack && tx_busy_r;
  assign push_data = (tx_cur_r == tx_fwa_r) ?
    {site_r, I_MEM_RDATA[DW-lab_pkg::SITE_W-1:0]} : I_MEM_RDATA; // RULE8
  // words nobody will store are drained so the sender never hangs
  assign pop      = rx_take || (f_out_vld && (!loop_r || !rx_busy_r));
  assign prot_fail = ms_r == lab_pkg::MS_RX_CHK && ack && I_MEM_PROT; // RULE13
  assign wr_ok    = ms_r == lab_pkg::MS_RX_WR && ack;
  assign tx_done  = push && tx_cur_r == tx_lwa_r; // RULE15
  assign rx_done  = rx_busy_r && (rx_short || prot_fail ||
                    (wr_ok && rx_cur_r == rx_lwa_r)); // RULE15
  assign rx_end_st = prot_fail ? lab_pkg::ST_PROT :
                     (wr_ok && (tx_busy_r || f_out_vld)) ?
                     lab_pkg::ST_OVF : lab_pkg::ST_IDLE; // RULE4

  lab_fifo #(
    .W (DW),
    .D (DEPTH)
  ) u_fifo (
    .i_clk       (I_CLK),
    .i_rst       (I_RST | rx_clr & tx_clr),
    .i_in_valid  (push),
    .i_in_data   (push_data),
    .o_in_ready  (f_in_rdy),
    .o_out_valid (f_out_vld),
    .o_out_data  (f_out_data),
    .i_out_ready (pop)
  );

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      ms_r        <= lab_pkg::MS_IDLE;
      mem_req_r   <= 1'b0;
      mem_we_r    <= 1'b0;
      mem_addr_r  <= '0;
      mem_wdata_r <= '0;
      rx_word_r   <= '0;
    end
    else
      case (ms_r)
        lab_pkg::MS_IDLE:
          if (rx_take)
          begin
            rx_word_r  <= f_out_data; // RULE7
            mem_req_r  <= 1'b1;
            mem_we_r   <= 1'b0;
            mem_addr_r <= rx_cur_r;
            ms_r       <= lab_pkg::MS_RX_CHK;
          end
          else if (tx_take)
          begin
            mem_req_r  <= 1'b1;
            mem_we_r   <= 1'b0;
            mem_addr_r <= tx_cur_r;
            ms_r       <= lab_pkg::MS_TX_RD;
          end
        lab_pkg::MS_RX_CHK:
          if (ack)
          begin
            // protect bit is sampled first so a refused word stays intact
            mem_req_r   <= !I_MEM_PROT && rx_busy_r; // RULE13
            mem_we_r    <= 1'b1;
            mem_wdata_r <= rx_word_r; // RULE7
            ms_r <= (!I_MEM_PROT && rx_busy_r) ? lab_pkg::MS_RX_WR
                                               : lab_pkg::MS_IDLE;
          end
        default:
          if (ack)
          begin
            mem_req_r <= 1'b0;
            mem_we_r  <= 1'b0;
            ms_r      <= lab_pkg::MS_IDLE;
          end
      endcase
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      link_stb_r  <= 1'b0;
      link_data_r <= '0;
    end
    else
    begin
      link_stb_r <= pop && !loop_r;
      if (pop && !loop_r)
        link_data_r <= f_out_data;
    end
  end

  // channel control: a clear and a start together leave the channel running
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      rx_busy_r   <= 1'b0;
      tx_busy_r   <= 1'b0;
      tx_ran_r    <= 1'b0;
      loop_r      <= 1'b0;
      rx_eop_en_r <= 1'b0;
      tx_eop_en_r <= 1'b0;
      rx_st_r     <= lab_pkg::ST_IDLE;
      tx_st_r     <= lab_pkg::ST_IDLE;
    end
    else
    begin
      rx_busy_r <= rx_go || (rx_busy_r && !rx_clr && !rx_done);
      tx_busy_r <= tx_go || (tx_busy_r && !tx_clr && !tx_done);
      tx_ran_r  <= tx_go || (tx_ran_r && !rx_go);
      if (rx_clr || rx_go)
        loop_r <= fn[lab_pkg::F_LOOP]; // RULE14
      if (rx_go)
        rx_eop_en_r <= fn[lab_pkg::F_EOP_EN]; // RULE6
      if (tx_go)
        tx_eop_en_r <= fn[lab_pkg::F_EOP_EN]; // RULE6
      if (rx_go)
        rx_st_r <= lab_pkg::ST_RUN; // RULE3
      else if (rx_clr)
        rx_st_r <= lab_pkg::ST_IDLE; // RULE2
      else if (rx_done)
        rx_st_r <= rx_end_st; // RULE4
      if (tx_go)
        tx_st_r <= lab_pkg::ST_RUN;
      else if (tx_clr || tx_done)
        tx_st_r <= lab_pkg::ST_IDLE; // RULE2 RULE4
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      rx_fwa_r <= '0;
      rx_lwa_r <= '0;
      tx_fwa_r <= '0;
      tx_lwa_r <= '0;
      rx_cur_r <= '0;
      tx_cur_r <= '0;
    end
    else
    begin
      if (wr_rx_fwa)
        rx_fwa_r <= merge(rx_fwa_r, I_WDATA, I_WSTRB); // RULE5
      if (wr_rx_lwa)
        rx_lwa_r <= merge(rx_lwa_r, I_WDATA, I_WSTRB); // RULE5
      if (wr_tx_fwa)
        tx_fwa_r <= merge(tx_fwa_r, I_WDATA, I_WSTRB); // RULE5
      if (wr_tx_lwa)
        tx_lwa_r <= merge(tx_lwa_r, I_WDATA, I_WSTRB); // RULE5
      if (rx_go)
        rx_cur_r <= rx_fwa_r;
      else if (wr_ok && rx_busy_r)
        rx_cur_r <= rx_cur_r + AW'(1); // RULE15
      if (tx_go)
        tx_cur_r <= tx_fwa_r;
      else if (push)
        tx_cur_r <= tx_cur_r + AW'(1); // RULE15
    end
  end

  // a completion in the clearing cycle survives the clear
  logic [1:0] irq_nxt;
  assign irq_nxt[lab_pkg::IRQ_RX] = (irq_st_r[lab_pkg::IRQ_RX] && !irq_clr) ||
                                    (rx_done && rx_eop_en_r); // RULE1 RULE6
  assign irq_nxt[lab_pkg::IRQ_TX] = (irq_st_r[lab_pkg::IRQ_TX] && !irq_clr) ||
                                    (tx_done && tx_eop_en_r); // RULE1 RULE6
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      irq_st_r <= '0;
      irq_r    <= 1'b0;
    end
    else
    begin
      irq_st_r <= irq_nxt; // RULE10
      irq_r    <= |irq_nxt; // RULE9
    end
  end

  assign O_AWREADY   = aw_ready_r;
  assign O_WREADY    = w_ready_r;
  assign O_BVALID    = bvalid_r;
  assign O_BRESP     = bresp_r;
  assign O_ARREADY   = ar_ready_r;
  assign O_RVALID    = rvalid_r;
  assign O_RDATA     = rdata_r;
  assign O_RRESP     = rresp_r;
  assign O_MEM_REQ   = mem_req_r;
  assign O_MEM_WE    = mem_we_r;
  assign O_MEM_ADDR  = mem_addr_r;
  assign O_MEM_WDATA = mem_wdata_r;
  assign O_LINK_DATA = link_data_r;
  assign O_LINK_STB  = link_stb_r;
  assign O_IRQ       = irq_r;
endmodule : lab_top

// [verification/lab_mem_model.sv]
`timescale 1ns/100ps
module lab_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic [1:0]  i_wait,
  output logic             o_ack,
  output logic [15:0]      o_rdata,
  output logic             o_prot
);
  logic [15:0] mem  [256];
  logic        prot [256];
  logic [1:0]  cnt_r = 2'h0;
  initial
  begin
    o_ack   = 1'h0;
    o_rdata = 16'h0;
    o_prot  = 1'h0;
  end
  // data lines toggle between acks so a late sample never looks valid
  always @(posedge i_clk)
  begin
    o_ack   <= 1'h0;
    o_rdata <= ~o_rdata;
    o_prot  <= ~o_prot;
    if (i_req === 1'h1 && o_ack !== 1'h1)
    begin
      if (cnt_r < i_wait)
        cnt_r <= cnt_r + 2'h1;
      else
      begin
        cnt_r   <= 2'h0;
        o_ack   <= 1'h1;
        o_rdata <= mem[i_addr[7:0]];
        o_prot  <= prot[i_addr[7:0]] === 1'h1;
        if (i_we)
          mem[i_addr[7:0]] <= i_wdata;
      end
    end
  end
endmodule : lab_mem_model

// [verification/lab_props.sv]
`timescale 1ns/100ps
module lab_props #(
  parameter int AW    = 16,
  parameter int DEPTH = 16
) (
  input wire logic          I_CLK,
  input wire logic          I_RST,
  input wire logic          I_AWVALID,
  input wire logic          I_WVALID,
  input wire logic          O_AWREADY,
  input wire logic          O_WREADY,
  input wire logic [1:0]    O_BRESP,
  input wire logic          O_BVALID,
  input wire logic          I_BREADY,
  input wire logic          O_ARREADY,
  input wire logic [31:0]   O_RDATA,
  input wire logic [1:0]    O_RRESP,
  input wire logic          O_RVALID,
  input wire logic          I_RREADY,
  input wire logic          O_MEM_REQ,
  input wire logic          O_MEM_WE,
  input wire logic [AW-1:0] O_MEM_ADDR,
  input wire logic [15:0]   O_MEM_WDATA,
  input wire logic          I_MEM_ACK,
  input wire logic          I_MEM_PROT,
  input wire logic          O_LINK_STB,
  input wire logic          O_IRQ
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);
  a_ready_cause: assert property (O_AWREADY |-> O_WREADY
    && $past(I_AWVALID && I_WVALID)) else $error("write taken unasked");
  a_aw_to_b: assert property (O_AWREADY |=> O_BVALID)
    else $error("write answer late");
  a_b_stands: assert property (O_BVALID && !I_BREADY |=>
    O_BVALID && $stable(O_BRESP)) else $error("write answer dropped");
  a_ar_to_r: assert property (O_ARREADY |=> O_RVALID)
    else $error("read answer late");
  a_r_stands: assert property (O_RVALID && !I_RREADY |=>
    O_RVALID && $stable(O_RDATA)) else $error("read answer dropped");
  a_decerr_zero: assert property (O_RVALID &&
    O_RRESP == lab_pkg::RESP_DEC |-> O_RDATA == 32'h0)
    else $error("unmapped read data not zero");
  a_rd_upper: assert property (O_RVALID |-> O_RDATA[31:16] == 16'h0)
    else $error("read upper half not zero");
  a_mem_stands: assert property (O_MEM_REQ && !I_MEM_ACK |=>
    O_MEM_REQ && $stable({O_MEM_WE, O_MEM_ADDR, O_MEM_WDATA}))
    else $error("memory request changed before ack");
  a_prot_refuse: assert property (I_MEM_ACK && !O_MEM_WE &&
    I_MEM_PROT |=> !(O_MEM_REQ && O_MEM_WE))
    else $error("protected word written");
  a_rx_same_addr: assert property (I_MEM_ACK && !O_MEM_WE ##1
    O_MEM_REQ && O_MEM_WE |-> O_MEM_ADDR == $past(O_MEM_ADDR))
    else $error("store address differs from probe");
  c_irq: cover property (O_IRQ);
  c_prot: cover property (I_MEM_ACK && I_MEM_PROT);
  c_link: cover property (O_LINK_STB);
  c_slverr: cover property (O_BVALID && O_BRESP == lab_pkg::RESP_SLV);
endmodule : lab_props
bind lab_top lab_props #(.AW(AW), .DEPTH(DEPTH)) u_props (.I_CLK(I_CLK),
  .I_RST(I_RST), .I_AWVALID(I_AWVALID), .I_WVALID(I_WVALID),
  .O_AWREADY(O_AWREADY), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP),
  .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .O_ARREADY(O_ARREADY),
  .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_RVALID(O_RVALID),
  .I_RREADY(I_RREADY), .O_MEM_REQ(O_MEM_REQ), .O_MEM_WE(O_MEM_WE),
  .O_MEM_ADDR(O_MEM_ADDR), .O_MEM_WDATA(O_MEM_WDATA),
  .I_MEM_ACK(I_MEM_ACK), .I_MEM_PROT(I_MEM_PROT),
  .O_LINK_STB(O_LINK_STB), .O_IRQ(O_IRQ));

// [verification/lab_top_bench.sv]
`timescale 1ns/100ps
module lab_top_bench;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0, site = 8'h5a;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  mem_wait = 2'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        mreq, mwe, mack, mprot, stb, irq;
  logic [1:0]  bresp, rresp;
  logic [15:0] maddr, mwdata, mrdata, ldata;
  logic [15:0] lq [$];
  int          err_count = 0, check_count = 0;
  always #2.5 clk = ~clk;
  lab_top u_dut (.I_CLK(clk), .I_RST(rst), .I_AWADDR(awaddr),
    .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata),
    .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready),
    .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
    .I_RREADY(rready), .O_MEM_REQ(mreq), .O_MEM_WE(mwe),
    .O_MEM_ADDR(maddr), .O_MEM_WDATA(mwdata), .I_MEM_ACK(mack),
    .I_MEM_RDATA(mrdata), .I_MEM_PROT(mprot), .I_SITE_ADDR(site),
    .O_LINK_DATA(ldata), .O_LINK_STB(stb), .O_IRQ(irq));
  lab_mem_model u_mem (.i_clk(clk), .i_req(mreq), .i_we(mwe),
    .i_addr(maddr), .i_wdata(mwdata), .i_wait(mem_wait), .o_ack(mack),
    .o_rdata(mrdata), .o_prot(mprot));
  always @(posedge clk)
    if (stb === 1'h1)
      lq.push_back(ldata);
  function automatic logic [15:0] txw(input int i);
    return 16'((i + 1) * 16'h1357);
  endfunction : txw
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] e);
    int n;
    n = 0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= {16'h0, d};
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
      if (awready === 1'h1)
        awvalid <= 1'h0;
      if (wready === 1'h1)
        wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 100);
    bready <= 1'h0;
    chk("bresp", {29'h0, 1'h1, e}, {29'h0, bvalid, bresp});
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
      if (arready === 1'h1)
        arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && n < 100);
    d = rdata;
    r = rresp;
    chk("rvalid", 32'h1, {31'h0, rvalid});
    rready <= 1'h0;
  endtask : rd
  task automatic wok(input logic [7:0] a, input logic [15:0] d);
    wr(a, d, lab_pkg::RESP_OKAY);
  endtask : wok
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk($sformatf("reg %h", a), {16'h0, e}, d);
    chk("rresp", {30'h0, lab_pkg::RESP_OKAY}, {30'h0, r});
  endtask : rchk
  task automatic s_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rchk(lab_pkg::OFF_RX_ST, lab_pkg::ST_IDLE);
    rchk(lab_pkg::OFF_TX_ST, lab_pkg::ST_IDLE);
    rchk(lab_pkg::OFF_IRQ_ST, 16'h0000);
    rchk(lab_pkg::OFF_FUNC, 16'h0000);
    rd(8'h80, d, r);
    chk("unmapped rresp", {30'h0, lab_pkg::RESP_DEC}, {30'h0, r});
    chk("unmapped rdata", 32'h0, d);
    wr(8'h84, 16'h1234, lab_pkg::RESP_DEC);
    wok(lab_pkg::OFF_RX_FWA, 16'h0123);
    rchk(lab_pkg::OFF_RX_FWA, 16'h0123);
  endtask : s_reset
  // tx buffer at 40, rx buffer at 80; pw marks a protected rx word
  task automatic s_buf(input int tn, input int rn, input int pw,
                       input logic [15:0] st, input logic [1:0] wt);
    logic [31:0] d;
    logic [1:0]  r;
    logic [15:0] e;
    int          n;
    mem_wait <= wt;
    site     <= site + 8'h11;
    for (int i = 0; i < 16; i++)
    begin
      u_mem.mem[8'h40 + i]  = txw(i);
      u_mem.mem[8'h80 + i]  = 16'hbada;
      u_mem.prot[8'h80 + i] = (i == pw);
    end
    wok(lab_pkg::OFF_FUNC, 16'h0023);
    rchk(lab_pkg::OFF_RX_ST, lab_pkg::ST_IDLE);
    rchk(lab_pkg::OFF_TX_ST, lab_pkg::ST_IDLE);
    wok(lab_pkg::OFF_RX_FWA, 16'h0080);
    wok(lab_pkg::OFF_RX_LWA, 16'(127 + rn));
    wok(lab_pkg::OFF_TX_FWA, 16'h0040);
    wok(lab_pkg::OFF_TX_LWA, 16'(63 + tn));
    wok(lab_pkg::OFF_FUNC, 16'h0034);
    rchk(lab_pkg::OFF_RX_ST, lab_pkg::ST_RUN);
    rchk(lab_pkg::OFF_TX_ST, lab_pkg::ST_IDLE);
    wr(lab_pkg::OFF_RX_LWA, 16'h0090, lab_pkg::RESP_SLV);
    wok(lab_pkg::OFF_FUNC, 16'h0018);
    n = 0;
    do
    begin
      rd(lab_pkg::OFF_IRQ_ST, d, r);
      n++;
    end while (d[1:0] !== 2'h3 && n < 200);
    chk("irq status", 32'h3, d);
    chk("irq line", 32'h1, {31'h0, irq});
    rchk(lab_pkg::OFF_RX_ST, st);
    rchk(lab_pkg::OFF_TX_ST, lab_pkg::ST_IDLE);
    for (int i = 0; i < 16; i++)
    begin
      e = (i < rn && i < tn && i != pw) ? txw(i) : 16'hbada;
      if (i == 0)
        e[15:8] = site;
      chk("rx word", 32'(e), 32'(u_mem.mem[8'h80 + i]));
    end
    chk("link strobes", 32'h0, 32'(lq.size()));
    wok(lab_pkg::OFF_FUNC, 16'h0040);
    rchk(lab_pkg::OFF_IRQ_ST, 16'h0000);
    chk("irq line", 32'h0, {31'h0, irq});
  endtask : s_buf
  task automatic s_link;
    logic [15:0] e;
    int          n;
    wok(lab_pkg::OFF_FUNC, 16'h0003);
    wok(lab_pkg::OFF_TX_FWA, 16'h0040);
    wok(lab_pkg::OFF_TX_LWA, 16'h0042);
    wok(lab_pkg::OFF_FUNC, 16'h0008);
    n = 0;
    while (lq.size() < 3 && n < 500)
    begin
      @(posedge clk);
      n++;
    end
    chk("link count", 32'h3, 32'(lq.size()));
    for (int i = 0; i < 3 && i < lq.size(); i++)
    begin
      e = txw(i);
      if (i == 0)
        e[15:8] = site;
      chk("link word", {16'h0, e}, {16'h0, lq[i]});
    end
    rchk(lab_pkg::OFF_TX_ST, lab_pkg::ST_IDLE);
    rchk(lab_pkg::OFF_RX_ST, lab_pkg::ST_IDLE);
    rchk(lab_pkg::OFF_IRQ_ST, 16'h0000);
  endtask : s_link
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    s_reset();
    s_buf(16, 16, -1, lab_pkg::ST_IDLE, 2'h0);
    s_buf(8, 4, -1, lab_pkg::ST_OVF, 2'h3);
    s_buf(4, 8, -1, lab_pkg::ST_IDLE, 2'h1);
    s_buf(2, 2, 1, lab_pkg::ST_PROT, 2'h0);
    s_link();
    report_and_stop();
  end
  // runs take about a thousand cycles; the limit leaves wide margin
  initial
  begin
    repeat (40000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
endmodule : lab_top_bench
